// ---- frms_pkg.sv ----
// constants and carrier types for the fixed rope memory selector
`default_nettype none
package frms_pkg;
	// register map (byte addresses, one aligned word each)
	localparam logic [11:0] OFS_ADDR = 12'h000;
	localparam logic [11:0] OFS_BANK = 12'h004;
	localparam logic [11:0] OFS_EXT = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	localparam logic [11:0] OFS_SENSE = 12'h010;
	// reset values
	localparam logic [11:0] RST_ADDR = 12'h000;
	localparam logic [4:0] RST_BANK = 5'h00;
	localparam logic [2:0] RST_EXT = 3'h0;
	// field positions inside the address word (bit n of S sits at n-1)
	localparam int POS_S08 = 7;
	localparam int POS_S09 = 8;
	localparam int POS_S10 = 9;
	localparam int POS_S11 = 10;
	localparam int POS_S12 = 11;
	// status word field positions
	localparam int POS_ST_FCR = 6;
	localparam int POS_ST_UNFIT = 7;
	// fixed store geometry
	localparam int BANK_W = 6;
	localparam int WORD_W = 10;
	localparam int NUM_BANKS = 64;
	localparam int WORDS_PER_BANK = 1024;
	localparam logic [5:0] BANKS_FITTED = 6'h24;
	localparam logic [5:0] FF_BANK_BASE = 6'h02;
	localparam int NUM_STRANDS = 72;
	localparam int NUM_MODULES = 6;
	localparam int NUM_ROPES = 3;
	localparam int STRANDS_PER_MODULE = 12;
	localparam int NUM_INHIBIT = 16;
	// strobe windows in timer pulse numbers, inclusive
	localparam logic [3:0] TP_IH_LO = 4'h2;
	localparam logic [3:0] TP_IH_HI = 4'h6;
	localparam logic [3:0] TP_SET_LO = 4'h3;
	localparam logic [3:0] TP_SET_HI = 4'h5;
	localparam logic [3:0] TP_GATE_LO = 4'h4;
	localparam logic [3:0] TP_GATE_HI = 4'h8;
	localparam logic [3:0] TP_SNS_LO = 4'h7;
	localparam logic [3:0] TP_SNS_HI = 4'h7;
	localparam logic [3:0] TP_RST_LO = 4'h9;
	localparam logic [3:0] TP_RST_HI = 4'hA;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic inhibit_driver_enable;
		logic set_enable;
		logic rope_strand_gate;
		logic reset_enable;
		logic fixed_sense_strobe;
	} frms_strobe_t;
endpackage
`default_nettype wire

// ---- frms_top.sv ----
// fixed rope memory address decode, cycle strobes and line selection
`default_nettype none
// Contract
// RQ1: fixed access only when address bit 12 or 11 is one
// RQ2: address bit 12 selects fixed-fixed area, bank and extension ignored
// RQ3: bit 12 zero, bit 11 one: bank from bank and extension registers
// RQ4: bank bits 16 and 14 not both one: extension register ignored
// RQ5: bank bits 16 and 14 both one: extension reaches upper bank groups
// RQ6: banks 30-77 need matching extension; banks 00-27 never need it
// RQ7: fixed space is 64 banks of 1024 words
// RQ8: banks 00-43 fitted; decoder leaves room for the rest
// RQ9: banks 02 and 03 form the fixed-fixed area
// RQ10: fixed-cycle request above octal 1777 governs fixed timing
// RQ11: five strobes sequenced by timer pulses and subinstruction command
// RQ12: lockout suppresses inhibit-enable and set-enable
// RQ13: restart suppresses gate, reset-enable and sense strobes
// RQ14: set strobe plus address bit 9 drives one of two set lines
// RQ15: reset strobe plus address bits 8,9 drives one of four resets
// RQ16: bits 1-7 pick 14 inhibit lines, X/Y give two, under enable
// RQ17: rope/strand from address bit 10 and bank bits; module from them
// RQ18: one rope of three, one strand of 72, one module of six
// RQ19: sensed word reaches memory buffer under sense strobe
// RQ20: no fixed request: all strobes and selections stay low
module frms_top
	import frms_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// axi4-lite slave
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// timer and sequence control
	input wire logic [3:0] timer_step,
	input wire logic fixed_read_cmd,
	input wire logic erasable_cycle_lockout,
	input wire logic restart_clear,
	// erasable side inhibit selections and sense amplifiers
	input wire logic x_inhibit_sel,
	input wire logic y_inhibit_sel,
	input wire logic [15:0] sense_word,
	// fixed memory drive
	output logic fixed_cycle_request,
	output frms_strobe_t strobes,
	output logic set_line_first,
	output logic set_line_second,
	output logic [3:0] reset_lines,
	output logic [NUM_INHIBIT-1:0] inhibit_lines,
	output logic [NUM_ROPES-1:0] rope_sel,
	output logic [NUM_STRANDS-1:0] strand_sel,
	output logic [NUM_MODULES-1:0] module_sel,
	output logic [15:0] mem_buffer
);

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [11:0] aw_addr;
		logic aw_hi;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [11:0] s_addr;
		logic [4:0] fixed_bank_reg;
		logic [2:0] ext;
		logic [BANK_W-1:0] bank_sel;
		logic unfitted;
		logic fcr;
		frms_strobe_t strb;
		logic [1:0] set_l;
		logic [3:0] rst_l;
		logic [NUM_INHIBIT-1:0] inh;
		logic [NUM_ROPES-1:0] rope;
		logic [NUM_STRANDS-1:0] strand;
		logic [NUM_MODULES-1:0] module_s;
		logic [15:0] mbuf;
	} frms_state_t;

	frms_state_t st_r;
	frms_state_t st_nxt;
	logic fcr_c;
	logic [BANK_W-1:0] bank_c;
	logic fitted_c;
	logic [BANK_W:0] strand_idx;
	logic active_c;
	frms_strobe_t strb_c;
	logic [NUM_STRANDS-1:0] strand_c;
	logic [NUM_MODULES-1:0] module_c;
	logic [NUM_ROPES-1:0] rope_c;

	function automatic logic win(input logic [3:0] tp, input logic [3:0] lo,
		input logic [3:0] hi);
		return (tp >= lo) && (tp <= hi);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// bank decode: fixed-fixed wins over bank registers
	always_comb begin
		fcr_c = st_r.s_addr[POS_S12] | st_r.s_addr[POS_S11]; // [RQ1] [RQ10]
		if (st_r.s_addr[POS_S12]) begin
			// [RQ2] [RQ9]
			bank_c = FF_BANK_BASE | BANK_W'(st_r.s_addr[POS_S11]);
		end else if (st_r.fixed_bank_reg[4:3] == 2'h3 && st_r.ext[2]) begin
			bank_c = {st_r.ext, st_r.fixed_bank_reg[2:0]}; // [RQ5] [RQ6] [RQ3]
		end else begin
			// extension 0-3 lands on the same banks 30-37 anyway
			bank_c = {1'b0, st_r.fixed_bank_reg}; // [RQ4] [RQ6] [RQ3]
		end
		// unfitted banks decode but select no rope, ready for expansion
		fitted_c = bank_c < BANKS_FITTED; // [RQ8] [RQ7]
		strand_idx = {bank_c, st_r.s_addr[POS_S10]}; // [RQ17]
	end

	// strobe timing
	always_comb begin
		active_c = fcr_c && fixed_read_cmd; // [RQ20] [RQ10]
		strb_c.inhibit_driver_enable = active_c && !erasable_cycle_lockout
			&& win(timer_step, TP_IH_LO, TP_IH_HI); // [RQ11] [RQ12]
		strb_c.set_enable = active_c && !erasable_cycle_lockout
			&& win(timer_step, TP_SET_LO, TP_SET_HI); // [RQ11] [RQ12]
		strb_c.rope_strand_gate = active_c && !restart_clear
			&& win(timer_step, TP_GATE_LO, TP_GATE_HI); // [RQ11] [RQ13]
		strb_c.reset_enable = active_c && !restart_clear
			&& win(timer_step, TP_RST_LO, TP_RST_HI); // [RQ11] [RQ13]
		strb_c.fixed_sense_strobe = active_c && !restart_clear
			&& win(timer_step, TP_SNS_LO, TP_SNS_HI); // [RQ11] [RQ13]
	end

	// strand decode, then module and rope from the strands
	for (genvar g = 0; g < NUM_STRANDS; g++) begin : g_strand
		assign strand_c[g] = strb_c.rope_strand_gate && fitted_c
			&& (strand_idx == (BANK_W+1)'(g)); // [RQ17] [RQ18]
	end
	for (genvar m = 0; m < NUM_MODULES; m++) begin : g_module
		assign module_c[m] =
			|strand_c[m*STRANDS_PER_MODULE +: STRANDS_PER_MODULE]; // [RQ17]
		if (m % 2 == 0) begin : g_rope
			assign rope_c[m/2] = module_c[m] | module_c[m+1]; // [RQ18]
		end
	end

	always_comb begin
		st_nxt = st_r;
		// write channel capture, address and data in either order
		if (awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = awaddr[11:0];
			st_nxt.aw_hi = |awaddr[31:12];
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = wdata;
			st_nxt.w_strb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			if (st_r.aw_hi) begin
				st_nxt.bresp = RESP_DECERR;
			end else begin
				unique case (st_r.aw_addr)
					OFS_ADDR: st_nxt.s_addr = 12'(merge({20'h0, st_r.s_addr},
						st_r.w_data, st_r.w_strb));
					OFS_BANK: st_nxt.fixed_bank_reg = 5'(merge({27'h0, st_r.fixed_bank_reg},
						st_r.w_data, st_r.w_strb));
					OFS_EXT: st_nxt.ext = 3'(merge({29'h0, st_r.ext},
						st_r.w_data, st_r.w_strb));
					OFS_STATUS, OFS_SENSE: begin
						// read-only words swallow writes
					end
					default: st_nxt.bresp = RESP_DECERR;
				endcase
			end
		end
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
		// read channel
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0;
			if (|araddr[31:12]) begin
				st_nxt.rresp = RESP_DECERR;
			end else begin
				unique case (araddr[11:0])
					OFS_ADDR: st_nxt.rdata = {20'h0, st_r.s_addr};
					OFS_BANK: st_nxt.rdata = {27'h0, st_r.fixed_bank_reg};
					OFS_EXT: st_nxt.rdata = {29'h0, st_r.ext};
					OFS_STATUS: st_nxt.rdata = {24'h0, st_r.unfitted,
						st_r.fcr, st_r.bank_sel};
					OFS_SENSE: st_nxt.rdata = {16'h0, st_r.mbuf};
					default: st_nxt.rresp = RESP_DECERR;
				endcase
			end
		end
		st_nxt.arready = !st_nxt.rvalid;
		// fixed memory drive
		st_nxt.fcr = fcr_c; // [RQ10]
		st_nxt.bank_sel = bank_c;
		st_nxt.unfitted = fcr_c && !fitted_c; // [RQ8]
		st_nxt.strb = strb_c; // [RQ11]
		st_nxt.set_l = strb_c.set_enable ? {st_r.s_addr[POS_S09],
			!st_r.s_addr[POS_S09]} : 2'h0; // [RQ14]
		st_nxt.rst_l = 4'h0;
		if (strb_c.reset_enable) begin
			st_nxt.rst_l[{st_r.s_addr[POS_S09], st_r.s_addr[POS_S08]}] =
				1'b1; // [RQ15]
		end
		st_nxt.inh = 16'h0;
		if (strb_c.inhibit_driver_enable) begin
			for (int k = 0; k < 7; k++) begin
				st_nxt.inh[2*k] = st_r.s_addr[k]; // [RQ16]
				st_nxt.inh[2*k+1] = !st_r.s_addr[k]; // [RQ16]
			end
			st_nxt.inh[14] = x_inhibit_sel; // [RQ16]
			st_nxt.inh[15] = y_inhibit_sel; // [RQ16]
		end
		st_nxt.strand = strand_c; // [RQ18]
		st_nxt.module_s = module_c; // [RQ17]
		st_nxt.rope = rope_c; // [RQ18]
		if (strb_c.fixed_sense_strobe) begin
			// sensed word arrives via the erasable sense amplifiers
			st_nxt.mbuf = sense_word; // [RQ19]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
			st_r.s_addr <= RST_ADDR;
			st_r.fixed_bank_reg <= RST_BANK;
			st_r.ext <= RST_EXT;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign awready = st_r.awready;
	assign wready = st_r.wready;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = st_r.arready;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	assign fixed_cycle_request = st_r.fcr;
	assign strobes = st_r.strb;
	assign set_line_first = st_r.set_l[1];
	assign set_line_second = st_r.set_l[0];
	assign reset_lines = st_r.rst_l;
	assign inhibit_lines = st_r.inh;
	assign rope_sel = st_r.rope;
	assign strand_sel = st_r.strand;
	assign module_sel = st_r.module_s;
	assign mem_buffer = st_r.mbuf;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_gate;
		st_r.strb.rope_strand_gate && !st_r.unfitted;
	endsequence
	sequence s_sense_hit;
		st_r.strb.fixed_sense_strobe;
	endsequence

	property p_fcr_track;
		##1 st_r.fcr == $past(st_r.s_addr[POS_S12] | st_r.s_addr[POS_S11]);
	endproperty
	a_fcr_track: assert property (p_fcr_track) // [RQ1] [RQ10]
		else $error("fixed request not following address bits 12/11");

	property p_quiet;
		!st_r.fcr |-> (st_r.strb == '0) && (st_r.strand == '0)
			&& (st_r.set_l == 2'h0) && (st_r.rst_l == 4'h0)
			&& (st_r.inh == '0);
	endproperty
	a_quiet: assert property (p_quiet) // [RQ20]
		else $error("fixed outputs active without fixed request");

	property p_ff_bank;
		##1 $past(st_r.s_addr[POS_S12]) |->
			st_r.bank_sel == (FF_BANK_BASE | 6'($past(st_r.s_addr[POS_S11])));
	endproperty
	a_ff_bank: assert property (p_ff_bank) // [RQ2] [RQ9]
		else $error("fixed-fixed access not on bank 02/03");

	property p_ext_ignored;
		##1 ($past(st_r.s_addr[POS_S12:POS_S11]) == 2'h1
			&& $past(st_r.fixed_bank_reg[4:3]) != 2'h3) |->
			st_r.bank_sel == {1'b0, $past(st_r.fixed_bank_reg)};
	endproperty
	a_ext_ignored: assert property (p_ext_ignored) // [RQ4] [RQ3]
		else $error("extension register affected a low bank");

	property p_lockout;
		##1 $past(erasable_cycle_lockout) |->
			!st_r.strb.inhibit_driver_enable && !st_r.strb.set_enable;
	endproperty
	a_lockout: assert property (p_lockout) // [RQ12]
		else $error("inhibit or set strobe during lockout");

	property p_restart;
		##1 $past(restart_clear) |-> !st_r.strb.rope_strand_gate
			&& !st_r.strb.reset_enable && !st_r.strb.fixed_sense_strobe;
	endproperty
	a_restart: assert property (p_restart) // [RQ13]
		else $error("gate, reset or sense strobe during restart");

	property p_set_line;
		st_r.strb.set_enable |-> $onehot(st_r.set_l)
			&& set_line_first == $past(st_r.s_addr[POS_S09]);
	endproperty
	a_set_line: assert property (p_set_line) // [RQ14]
		else $error("set line decode wrong");

	property p_reset_line;
		st_r.strb.reset_enable |-> $onehot(st_r.rst_l)
			&& st_r.rst_l[$past(st_r.s_addr[POS_S09:POS_S08])];
	endproperty
	a_reset_line: assert property (p_reset_line) // [RQ15]
		else $error("reset line decode wrong");

	property p_select;
		s_gate |-> $onehot(st_r.strand) && $onehot(st_r.module_s)
			&& $onehot(st_r.rope);
	endproperty
	a_select: assert property (p_select) // [RQ18]
		else $error("rope, strand or module not one-hot");

	property p_sense;
		s_sense_hit |-> st_r.mbuf == $past(sense_word);
	endproperty
	a_sense: assert property (p_sense) // [RQ19]
		else $error("memory buffer missed the sensed word");

	property p_bhold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped before bready");

endmodule
`default_nettype wire

// ---- frms_seq_model.sv ----
// timer and sequence model standing in for the central processor
`default_nettype none
module frms_seq_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bench control
	input wire logic run,
	// timer and command
	output logic [3:0] timer_step,
	output logic fixed_read_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	// idles at step zero between cycles so no stale pulse is seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_step <= 4'h0;
			fixed_read_cmd <= 1'b0;
		end else if (!run) begin
			timer_step <= 4'h0;
			fixed_read_cmd <= 1'b0;
		end else begin
			timer_step <= (timer_step == 4'hC) ? 4'h1 : timer_step + 4'h1;
			fixed_read_cmd <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the fixed rope memory selector
`default_nettype none
module tb_top
	import frms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, run = 1'b0;
	logic lockout = 1'b0, restart = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [15:0] sense_word = 16'h0;
	logic awready, wready, bvalid, arready, rvalid, fixed_cycle_request;
	logic set_line_first, set_line_second, fixed_read_cmd;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rv;
	logic [3:0] timer_step, reset_lines;
	frms_strobe_t strobes;
	logic [15:0] inhibit_lines, mem_buffer;
	logic [15:0] mb = 16'h0;
	logic [2:0] rope_sel;
	logic [71:0] strand_sel;
	logic [5:0] module_sel;
	int miscompares = 0, compares = 0;
	logic [11:0] sa [8] = '{12'h6D5, 12'hA2B, 12'hC94, 12'h53A,
		12'h4C6, 12'h4C6, 12'h3FF, 12'h400};
	logic [4:0] ba [8] = '{5'h0F, 5'h1F, 5'h1F, 5'h18,
		5'h18, 5'h1B, 5'h01, 5'h10};
	logic [2:0] ea [8] = '{3'h7, 3'h7, 3'h7, 3'h3, 3'h5, 3'h4, 3'h0, 3'h7};
	logic [5:0] xa [8] = '{6'h0F, 6'h02, 6'h03, 6'h18,
		6'h28, 6'h23, 6'h01, 6'h10};

	always #5 clk_sys = ~clk_sys;

	frms_top uut (.clk_sys, .rst, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .timer_step,
		.fixed_read_cmd, .erasable_cycle_lockout(lockout),
		.restart_clear(restart), .x_inhibit_sel(sense_word[0]),
		.y_inhibit_sel(sense_word[1]), .sense_word, .fixed_cycle_request,
		.strobes, .set_line_first, .set_line_second, .reset_lines,
		.inhibit_lines, .rope_sel, .strand_sel, .module_sel, .mem_buffer);
	frms_seq_model seq (.clk_sys, .rst, .run, .timer_step, .fixed_read_cmd);

	task automatic chk(input logic [71:0] g, input logic [71:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wrap_up();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic hang();
		miscompares++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		wrap_up();
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		awaddr <= {20'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			hang();
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge clk_sys);
		araddr <= {20'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rv = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			hang();
	endtask

	// one full timer cycle, every drive output except the fixed request checked against the step seen
	task automatic cyc(input logic [11:0] s, input logic [5:0] bk,
		input logic lk, input logic rt, input logic [15:0] sw);
		logic [3:0] t;
		logic f, ih, se, g, rr, sn;
		logic [15:0] inh;
		int k, idx;
		@(posedge clk_sys);
		lockout <= lk;
		restart <= rt;
		sense_word <= sw;
		run <= 1'b1;
		// sample the model half a cycle ahead of the edge the design uses
		@(negedge clk_sys);
		t = timer_step;
		f = fixed_read_cmd && (s[11] || s[10]);
		repeat (14) begin
			@(negedge clk_sys);
			ih = f && !lk && t >= TP_IH_LO && t <= TP_IH_HI;
			se = f && !lk && t >= TP_SET_LO && t <= TP_SET_HI;
			g = f && !rt && t >= TP_GATE_LO && t <= TP_GATE_HI;
			rr = f && !rt && t >= TP_RST_LO && t <= TP_RST_HI;
			sn = f && !rt && t >= TP_SNS_LO && t <= TP_SNS_HI;
			chk(strobes, {ih, se, g, rr, sn});
			chk({set_line_first, set_line_second}, {se & s[8], se & !s[8]});
			chk(reset_lines, rr ? 4'h1 << {s[8], s[7]} : 4'h0);
			for (k = 0; k < 7; k++)
				inh[2*k +: 2] = {!s[k], s[k]};
			inh[15:14] = sw[1:0];
			chk(inhibit_lines, ih ? inh : 16'h0);
			idx = bk * 2 + s[9];
			g = g && bk < BANKS_FITTED;
			chk(strand_sel, g ? 72'h1 << idx : 72'h0);
			chk(module_sel, g ? 6'h1 << (idx / 12) : 6'h0);
			chk(rope_sel, g ? 3'h1 << (idx / 24) : 3'h0);
			if (sn)
				mb = sw;
			chk(mem_buffer, mb);
			t = timer_step;
			f = fixed_read_cmd && (s[11] || s[10]);
		end
		@(posedge clk_sys);
		run <= 1'b0;
		lockout <= 1'b0;
		restart <= 1'b0;
		rd(OFS_SENSE);
		chk(rv, {16'h0, mb});
	endtask

	initial begin
		int i;
		logic f;
		logic [31:0] m, e;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(OFS_ADDR);
		chk(rv, RST_ADDR);
		rd(OFS_BANK);
		chk(rv, RST_BANK);
		rd(OFS_EXT);
		chk(rv, RST_EXT);
		rd(12'h020);
		chk({rs, rv}, {RESP_DECERR, 32'h0});
		wr(12'h020, 32'h5);
		chk(rs, RESP_DECERR);
		// no byte enables: the write must leave the register alone
		wstrb <= 4'h0;
		wr(OFS_EXT, 32'h7);
		wstrb <= 4'hF;
		chk(rs, RESP_OKAY);
		rd(OFS_EXT);
		chk(rv, RST_EXT);
		// status is read-only: a write must leave its fcr and unfitted bits (7:6) clear
		wr(OFS_STATUS, 32'hFF);
		rd(OFS_STATUS);
		chk(rv & 32'hC0, 32'h0);
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			wr(OFS_ADDR, {20'h0, sa[i]});
			wr(OFS_BANK, {27'h0, ba[i]});
			wr(OFS_EXT, {29'h0, ea[i]});
			rd(OFS_BANK);
			chk(rv, {27'h0, ba[i]});
			f = sa[i][11] | sa[i][10];
			chk(fixed_cycle_request, f);
			rd(OFS_STATUS);
			m = f ? 32'hFF : 32'hC0;
			e = {24'h0, xa[i] >= BANKS_FITTED && f, f, xa[i]} & m;
			chk(rv & m, e);
			cyc(sa[i], xa[i], i[0], i[1],
				16'h5A3C ^ {i[3:0], i[3:0], i[3:0], i[3:0]});
			$display("test decode %0d done", i);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
